// *** cmt_pkg.sv ***
// package: register map, fixed tables and float conversion for the colour matrix stage
package cmt_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_UNIT_SEL = 8'h04;
  localparam logic [7:0] OFF_UNIT_ON = 8'h08;
  localparam logic [7:0] OFF_COEFF_INDEX = 8'h0C;
  localparam logic [7:0] OFF_COEFF_VALUE = 8'h10;
  localparam logic [7:0] OFF_ILLUMINANT = 8'h14;
  localparam logic [7:0] OFF_SATURATION = 8'h18;
  localparam logic [7:0] OFF_RED_WB = 8'h1C;
  localparam logic [7:0] OFF_BLUE_WB = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // control and status field positions
  localparam int CTRL_PIPE_ON = 0;
  localparam int CTRL_FMT_YUV = 1;
  localparam int CTRL_BOOST_ON = 2;
  localparam int ST_COLOUR_OK = 0;
  localparam int ST_MATRIX_LIVE = 1;
  localparam int ST_LUMA_LIVE = 2;
  localparam int ST_BOOST_LIVE = 3;
  // coefficient format: signed Q3.12
  localparam int CW = 16;
  localparam int FRAC = 12;
  localparam int NCOEF = 12;
  localparam int NPRESET = 7;
  localparam int IDX_BIAS0 = 9;
  localparam logic [31:0] FLT_ONE = 32'h3F800000;
  localparam logic [15:0] FIX_MAX = 16'h7FFF;
  localparam logic [15:0] FIX_MIN = 16'h8000;
  // reset values
  localparam logic RST_PIPE_ON = 1'b0;
  localparam logic RST_UNIT_ON = 1'b1;
  typedef enum logic [2:0] {
    ILL_GENERAL, ILL_TUNGSTEN, ILL_WARM_FL, ILL_COOL_FL,
    ILL_DAYLIGHT, ILL_CLOUDY, ILL_SHADE, ILL_CUSTOM
  } cmt_illum_t;
  typedef enum logic {UNIT_NATIVE, UNIT_LUMA} cmt_unit_t;
  // identity set, index 0 in the low word
  localparam logic [NCOEF*CW-1:0] IDENT_SET = {16'h0000, 16'h0000, 16'h0000,
    16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h1000, 16'h0000,
    16'h0000, 16'h0000, 16'h1000};
  // fixed luma/chroma set, chroma biases at half scale
  localparam logic [NCOEF*CW-1:0] LUMA_SET = {16'h0800, 16'h0800, 16'h0000,
    16'hFEB3, 16'hF94D, 16'h0800, 16'h0800, 16'hFAB3, 16'hFD4D,
    16'h01D3, 16'h0964, 16'h04C9};
  localparam logic [NPRESET*NCOEF*CW-1:0] PRESET_SETS_DFLT = {NPRESET{IDENT_SET}};
  localparam logic [NPRESET*32-1:0] PRESET_WB_DFLT = {NPRESET{FLT_ONE}};

  // single float to Q3.12, saturating
  function automatic logic [15:0] fltToFix(input logic [31:0] f);
    int sh;
    logic [47:0] mag;
    logic [15:0] r;
    sh = int'(f[30:23]) - 138;
    mag = 48'h0;
    if (f[30:23] == 8'h00) mag = 48'h0;
    else if (sh > 20) mag = 48'hFFFF;
    else if (sh >= 0) mag = {24'h0, 1'b1, f[22:0]} << sh;
    else if (sh > -25) mag = {24'h0, 1'b1, f[22:0]} >> (-sh);
    if (!f[31]) r = (mag > 48'h7FFF) ? FIX_MAX : mag[15:0];
    else r = (mag > 48'h8000) ? FIX_MIN : 16'(-mag[15:0]);
    return r;
  endfunction

  // Q3.12 back to single float, exact
  function automatic logic [31:0] fixToFlt(input logic [15:0] x);
    logic [15:0] mag;
    logic [38:0] t;
    int p;
    mag = x[15] ? 16'(-x) : x;
    p = 0;
    for (int i = 0; i < 16; i++) if (mag[i]) p = i;
    t = {23'h0, mag} << (23 - p);
    if (mag == 16'h0000) return 32'h00000000;
    return {x[15], 8'(p + 115), t[22:0]};
  endfunction
endpackage

// *** cmt_matrix3.sv ***
// one registered 3x3 matrix plus bias stage with clamped outputs
`timescale 1ns/1ps
module cmt_matrix3 #(
  parameter int PW = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic enable,
  input wire logic [cmt_pkg::NCOEF*cmt_pkg::CW-1:0] coef,
  // pixel in
  input wire logic inValid,
  input wire logic inSof,
  input wire logic [PW-1:0] inR,
  input wire logic [PW-1:0] inG,
  input wire logic [PW-1:0] inB,
  // pixel out
  output logic outValid,
  output logic outSof,
  output logic [PW-1:0] out0,
  output logic [PW-1:0] out1,
  output logic [PW-1:0] out2
);
  localparam int AW = PW + cmt_pkg::CW + 4;
  localparam logic signed [AW-1:0] PMAX = AW'((1 << PW) - 1);
  logic [PW-1:0] pix [3];
  logic [PW-1:0] res [3];
  logic signed [AW-1:0] acc;

  function automatic logic signed [AW-1:0] term(input logic [cmt_pkg::CW-1:0] c,
                                                input logic [PW-1:0] p);
    return AW'($signed(c)) * AW'($signed({1'b0, p}));
  endfunction

  // weighted sum per row, then clamp so the next stage never wraps
  always_comb begin
    pix[0] = inR;
    pix[1] = inG;
    pix[2] = inB;
    acc = '0;
    for (int i = 0; i < 3; i++) begin
      acc = AW'($signed(coef[(cmt_pkg::IDX_BIAS0+i)*cmt_pkg::CW +: cmt_pkg::CW])) <<< PW;
      for (int j = 0; j < 3; j++) begin
        acc = acc + term(coef[(i*3 + j)*cmt_pkg::CW +: cmt_pkg::CW], pix[j]);
      end
      acc = acc >>> cmt_pkg::FRAC;
      if (acc < 0) res[i] = '0;
      else if (acc > PMAX) res[i] = PMAX[PW-1:0];
      else res[i] = acc[PW-1:0];
    end
  end

  // output register, bypass passes pixels unchanged
  always_ff @(posedge clk) begin
    if (reset) begin
      outValid <= 1'b0;
      outSof <= 1'b0;
      out0 <= '0;
      out1 <= '0;
      out2 <= '0;
    end else begin
      outValid <= inValid;
      outSof <= inSof & inValid;
      out0 <= enable ? res[0] : inR;
      out1 <= enable ? res[1] : inG;
      out2 <= enable ? res[2] : inB;
    end
  end
endmodule // cmt_matrix3

// *** cmt_color_matrix_transform.sv ***
// colour matrix stage: apb registers, native matrix, luma/chroma and saturation
`timescale 1ns/1ps
module cmt_color_matrix_transform #(
  parameter int PW = 10,
  parameter bit COLOR_VARIANT = 1'b1,
  parameter logic [cmt_pkg::NPRESET*cmt_pkg::NCOEF*cmt_pkg::CW-1:0] PRESET_SETS =
    cmt_pkg::PRESET_SETS_DFLT,
  parameter logic [cmt_pkg::NPRESET*32-1:0] PRESET_WB_RED = cmt_pkg::PRESET_WB_DFLT,
  parameter logic [cmt_pkg::NPRESET*32-1:0] PRESET_WB_BLUE = cmt_pkg::PRESET_WB_DFLT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pixels from upstream
  input wire logic pixValid,
  input wire logic pixSof,
  input wire logic [PW-1:0] pixR,
  input wire logic [PW-1:0] pixG,
  input wire logic [PW-1:0] pixB,
  // to and from the gamma stage
  output logic toGammaValid,
  output logic toGammaSof,
  output logic [PW-1:0] toGammaR,
  output logic [PW-1:0] toGammaG,
  output logic [PW-1:0] toGammaB,
  input wire logic gamValid,
  input wire logic gamSof,
  input wire logic [PW-1:0] gamR,
  input wire logic [PW-1:0] gamG,
  input wire logic [PW-1:0] gamB,
  // pixels to downstream
  output logic outValid,
  output logic outSof,
  output logic [PW-1:0] out0,
  output logic [PW-1:0] out1,
  output logic [PW-1:0] out2,
  // white-balance gains for the balance stage
  output logic [31:0] redWbGain,
  output logic [31:0] blueWbGain
);
  localparam int SW = PW + cmt_pkg::CW + 4;
  localparam logic [PW-1:0] MID = PW'(1 << (PW - 1));

  // software state
  logic pipeOn, fmtYuv, boostOn, ccmOn;
  cmt_pkg::cmt_unit_t unitSel;
  cmt_pkg::cmt_illum_t illum;
  logic [3:0] coefIdx;
  logic [cmt_pkg::CW-1:0] custom [cmt_pkg::NCOEF];
  logic [31:0] satVal;
  // frame-latched state
  logic [cmt_pkg::NCOEF*cmt_pkg::CW-1:0] frmSet;
  logic frmCcmOn, frmYuv, frmBoost, yuvUse, satUse, satYuvMode;
  logic [cmt_pkg::CW-1:0] frmSat, satFix;
  // combinational
  logic colourOk, accOk, wrEn, setupRd, unmapped, gated;
  logic [cmt_pkg::NCOEF*cmt_pkg::CW-1:0] customFlat, stagedSet, ccmCoef;
  logic [31:0] rdData;
  logic [cmt_pkg::CW-1:0] coefInUse;
  logic ccmEnable, yuvEnable;
  logic yValid, ySof;
  logic [PW-1:0] y0, y1, y2, mean;
  logic [PW+1:0] sumRgb;

  // scale distance from centre m by saturation s, clamped to pixel range
  function automatic logic [PW-1:0] satScale(input logic [PW-1:0] c, input logic [PW-1:0] m,
                                             input logic [cmt_pkg::CW-1:0] s);
    logic signed [SW-1:0] v;
    v = SW'($signed({1'b0, c})) - SW'($signed({1'b0, m}));
    v = (v * SW'($signed(s))) >>> cmt_pkg::FRAC;
    v = v + SW'($signed({1'b0, m}));
    if (v < 0) return '0;
    if (v > SW'((1 << PW) - 1)) return '1;
    return v[PW-1:0];
  endfunction

  // access gating: monochrome builds and a stopped pipeline hide the controls
  assign colourOk = COLOR_VARIANT && pipeOn;
  always_comb begin
    for (int k = 0; k < cmt_pkg::NCOEF; k++) begin
      customFlat[k*cmt_pkg::CW +: cmt_pkg::CW] = custom[k];
    end
  end
  // preset tables unless custom is chosen
  assign stagedSet = (illum == cmt_pkg::ILL_CUSTOM) ? customFlat :
    PRESET_SETS[int'(illum)*cmt_pkg::NCOEF*cmt_pkg::CW +: cmt_pkg::NCOEF*cmt_pkg::CW];

  // address decode
  always_comb begin
    unmapped = 1'b0;
    gated = 1'b1;
    if (paddr == cmt_pkg::OFF_CTRL) gated = 1'b0;
    else if (paddr == cmt_pkg::OFF_STATUS) gated = 1'b0;
    else if (paddr == cmt_pkg::OFF_UNIT_SEL) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_UNIT_ON) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_COEFF_INDEX) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_COEFF_VALUE) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_ILLUMINANT) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_SATURATION) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_RED_WB) gated = 1'b1;
    else if (paddr == cmt_pkg::OFF_BLUE_WB) gated = 1'b1;
    else unmapped = 1'b1;
  end
  assign accOk = !unmapped && (!gated || colourOk);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !accOk;
  assign wrEn = psel && penable && pwrite && accOk;
  assign setupRd = psel && !penable && !pwrite;

  // coefficient in use at the index: live frame set or the fixed luma set
  always_comb begin
    coefInUse = '0;
    if (coefIdx < 4'(cmt_pkg::NCOEF)) begin
      if (unitSel == cmt_pkg::UNIT_LUMA)
        coefInUse = cmt_pkg::LUMA_SET[coefIdx*cmt_pkg::CW +: cmt_pkg::CW];
      else coefInUse = frmSet[coefIdx*cmt_pkg::CW +: cmt_pkg::CW];
    end
  end

  // read mux
  always_comb begin
    rdData = 32'h00000000;
    if (!accOk) rdData = 32'h00000000;
    else if (paddr == cmt_pkg::OFF_CTRL) rdData = {29'h0, boostOn, fmtYuv, pipeOn};
    else if (paddr == cmt_pkg::OFF_STATUS) rdData = {28'h0, frmBoost, frmYuv, frmCcmOn, colourOk};
    else if (paddr == cmt_pkg::OFF_UNIT_SEL) rdData = {31'h0, unitSel};
    else if (paddr == cmt_pkg::OFF_UNIT_ON)
      rdData = {31'h0, (unitSel == cmt_pkg::UNIT_LUMA) ? fmtYuv : ccmOn};
    else if (paddr == cmt_pkg::OFF_COEFF_INDEX) rdData = {28'h0, coefIdx};
    else if (paddr == cmt_pkg::OFF_COEFF_VALUE) rdData = cmt_pkg::fixToFlt(coefInUse);
    else if (paddr == cmt_pkg::OFF_ILLUMINANT) rdData = {29'h0, illum};
    else if (paddr == cmt_pkg::OFF_SATURATION) rdData = satVal;
    else if (paddr == cmt_pkg::OFF_RED_WB) rdData = redWbGain;
    else if (paddr == cmt_pkg::OFF_BLUE_WB) rdData = blueWbGain;
  end

  // read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge clk) begin
    if (reset) prdata <= 32'h00000000;
    else if (setupRd) prdata <= rdData;
  end

  // control and selector registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pipeOn <= cmt_pkg::RST_PIPE_ON;
      fmtYuv <= 1'b0;
      boostOn <= 1'b0;
      unitSel <= cmt_pkg::UNIT_NATIVE;
      ccmOn <= cmt_pkg::RST_UNIT_ON;
      coefIdx <= 4'h0;
      satVal <= cmt_pkg::FLT_ONE;
    end else if (wrEn) begin
      if (paddr == cmt_pkg::OFF_CTRL) begin
        pipeOn <= pwdata[cmt_pkg::CTRL_PIPE_ON];
        fmtYuv <= pwdata[cmt_pkg::CTRL_FMT_YUV];
        boostOn <= pwdata[cmt_pkg::CTRL_BOOST_ON];
      end else if (paddr == cmt_pkg::OFF_UNIT_SEL) begin
        unitSel <= cmt_pkg::cmt_unit_t'(pwdata[0]);
      end else if (paddr == cmt_pkg::OFF_UNIT_ON) begin
        if (unitSel == cmt_pkg::UNIT_NATIVE) ccmOn <= pwdata[0];
      end else if (paddr == cmt_pkg::OFF_COEFF_INDEX) begin
        coefIdx <= pwdata[3:0];
      end else if (paddr == cmt_pkg::OFF_SATURATION) begin
        satVal <= pwdata;
      end
    end
  end

  // illuminant choice and white-balance gains; later gain writes override
  always_ff @(posedge clk) begin
    if (reset) begin
      illum <= cmt_pkg::ILL_GENERAL;
      redWbGain <= PRESET_WB_RED[31:0];
      blueWbGain <= PRESET_WB_BLUE[31:0];
    end else if (wrEn) begin
      if (paddr == cmt_pkg::OFF_ILLUMINANT) begin
        illum <= cmt_pkg::cmt_illum_t'(pwdata[2:0]);
        if (pwdata[2:0] != 3'h7) begin
          redWbGain <= PRESET_WB_RED[int'(pwdata[2:0])*32 +: 32];
          blueWbGain <= PRESET_WB_BLUE[int'(pwdata[2:0])*32 +: 32];
        end
      end else if (paddr == cmt_pkg::OFF_RED_WB) begin
        redWbGain <= pwdata;
      end else if (paddr == cmt_pkg::OFF_BLUE_WB) begin
        blueWbGain <= pwdata;
      end
    end
  end

  // custom bank, stored fixed; luma unit coefficients are constants
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < cmt_pkg::NCOEF; k++) begin
        custom[k] <= cmt_pkg::IDENT_SET[k*cmt_pkg::CW +: cmt_pkg::CW];
      end
    end else if (wrEn && paddr == cmt_pkg::OFF_COEFF_VALUE &&
                 unitSel == cmt_pkg::UNIT_NATIVE && coefIdx < 4'(cmt_pkg::NCOEF)) begin
      custom[coefIdx] <= cmt_pkg::fltToFix(pwdata);
    end
  end

  // snapshot of every pixel-path setting at start of frame, so no frame mixes old and new; the white-balance gains change at once
  always_ff @(posedge clk) begin
    if (reset) begin
      frmSet <= cmt_pkg::IDENT_SET;
      frmCcmOn <= 1'b0;
      frmYuv <= 1'b0;
      frmBoost <= 1'b0;
      frmSat <= cmt_pkg::IDENT_SET[cmt_pkg::CW-1:0];
    end else if (pixValid && pixSof) begin
      frmSet <= stagedSet;
      frmCcmOn <= colourOk && ccmOn;
      frmYuv <= colourOk && fmtYuv;
      frmBoost <= colourOk && boostOn;
      frmSat <= cmt_pkg::fltToFix(satVal);
    end
  end

  // the first pixel of a frame already uses the new settings
  assign ccmCoef = pixSof ? stagedSet : frmSet;
  assign ccmEnable = pixSof ? (colourOk && ccmOn) : frmCcmOn;

  cmt_matrix3 #(.PW(PW)) u_native (
    .clk(clk),
    .reset(reset),
    .enable(ccmEnable),
    .coef(ccmCoef),
    .inValid(pixValid),
    .inSof(pixSof),
    .inR(pixR),
    .inG(pixG),
    .inB(pixB),
    .outValid(toGammaValid),
    .outSof(toGammaSof),
    .out0(toGammaR),
    .out1(toGammaG),
    .out2(toGammaB)
  );

  // luma/chroma on-flag held per frame at the gamma stage's frame start
  always_ff @(posedge clk) begin
    if (reset) yuvUse <= 1'b0;
    else if (gamValid && gamSof) yuvUse <= frmYuv;
  end
  assign yuvEnable = gamSof ? frmYuv : yuvUse;

  // conversion sits behind gamma: fed from the gamma return path
  cmt_matrix3 #(.PW(PW)) u_luma (
    .clk(clk),
    .reset(reset),
    .enable(yuvEnable),
    .coef(cmt_pkg::LUMA_SET),
    .inValid(gamValid),
    .inSof(gamSof),
    .inR(gamR),
    .inG(gamG),
    .inB(gamB),
    .outValid(yValid),
    .outSof(ySof),
    .out0(y0),
    .out1(y1),
    .out2(y2)
  );

  // saturation settings follow the frame at this stage's own frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      satUse <= 1'b0;
      satFix <= cmt_pkg::IDENT_SET[cmt_pkg::CW-1:0];
      satYuvMode <= 1'b0;
    end else if (yValid && ySof) begin
      satUse <= frmBoost;
      satFix <= frmSat;
      satYuvMode <= yuvUse;
    end
  end

  // rgb centre is a cheap luma estimate; chroma centre is half scale
  assign sumRgb = {2'b00, y0} + {1'b0, y1, 1'b0} + {2'b00, y2};
  assign mean = sumRgb[PW+1:2];

  // saturation stage; a level above one spreads colours away from grey
  always_ff @(posedge clk) begin
    if (reset) begin
      outValid <= 1'b0;
      outSof <= 1'b0;
      out0 <= '0;
      out1 <= '0;
      out2 <= '0;
    end else begin
      outValid <= yValid;
      outSof <= ySof;
      if (!(ySof ? frmBoost : satUse)) begin
        out0 <= y0;
        out1 <= y1;
        out2 <= y2;
      end else if (ySof ? yuvUse : satYuvMode) begin
        out0 <= y0;
        out1 <= satScale(y1, MID, ySof ? frmSat : satFix);
        out2 <= satScale(y2, MID, ySof ? frmSat : satFix);
      end else begin
        out0 <= satScale(y0, mean, ySof ? frmSat : satFix);
        out1 <= satScale(y1, mean, ySof ? frmSat : satFix);
        out2 <= satScale(y2, mean, ySof ? frmSat : satFix);
      end
    end
  end
endmodule // cmt_color_matrix_transform

// *** cmt_transform_monitor.sv ***
// assertion checker watching the colour matrix stage ports
`timescale 1ns/1ps
module cmt_transform_monitor #(
  parameter int PW = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pixel path
  input wire logic pixValid,
  input wire logic pixSof,
  input wire logic [PW-1:0] pixR,
  input wire logic [PW-1:0] pixG,
  input wire logic [PW-1:0] pixB,
  input wire logic toGammaValid,
  input wire logic toGammaSof,
  input wire logic [PW-1:0] toGammaR,
  input wire logic [PW-1:0] toGammaG,
  input wire logic [PW-1:0] toGammaB,
  input wire logic gamValid,
  input wire logic outValid,
  // gains
  input wire logic [31:0] redWbGain
);
  logic pipeOn;
  logic pipeLive;
  // pipeline bit as written; the control word itself is never gated
  always_ff @(posedge clk) begin
    if (reset) pipeOn <= 1'b0;
    else if (psel && penable && pwrite && paddr == cmt_pkg::OFF_CTRL) pipeOn <= pwdata[0];
  end
  // frame copy, since the pixel path only switches at frame start
  always_ff @(posedge clk) begin
    if (reset) pipeLive <= 1'b0;
    else if (pixValid && pixSof) pipeLive <= pipeOn;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_errPhase; pslverr |-> psel && penable; endproperty
  a_errPhase: assert property (p_errPhase) else $error("error outside access");
  property p_gated;
    psel && penable && !pipeOn && paddr != cmt_pkg::OFF_CTRL
      && paddr != cmt_pkg::OFF_STATUS |-> pslverr;
  endproperty
  a_gated: assert property (p_gated) else $error("gated register answered");
  property p_unmapped;
    psel && penable && !pwrite && paddr > cmt_pkg::OFF_STATUS |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_tgSof; pixValid && pixSof |=> toGammaValid && toGammaSof; endproperty
  a_tgSof: assert property (p_tgSof) else $error("frame start lost");
  property p_tgIdle; !pixValid |=> !toGammaValid && !toGammaSof; endproperty
  a_tgIdle: assert property (p_tgIdle) else $error("pixel out of nothing");
  property p_outLat; gamValid |-> ##2 outValid; endproperty
  a_outLat: assert property (p_outLat) else $error("final pixel missing");
  property p_bypass;
    pixValid && !(pixSof ? pipeOn : pipeLive) |=> toGammaR == $past(pixR)
      && toGammaG == $past(pixG) && toGammaB == $past(pixB);
  endproperty
  a_bypass: assert property (p_bypass) else $error("pixel changed while off");
  property p_wb;
    psel && penable && pwrite && !pslverr && paddr == cmt_pkg::OFF_RED_WB
      |=> redWbGain == $past(pwdata);
  endproperty
  a_wb: assert property (p_wb) else $error("red gain not overridden");
endmodule // cmt_transform_monitor

bind cmt_color_matrix_transform cmt_transform_monitor #(.PW(PW)) i_mon (.clk, .reset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pixValid,
  .pixSof, .pixR, .pixG, .pixB, .toGammaValid, .toGammaSof, .toGammaR, .toGammaG,
  .toGammaB, .gamValid, .outValid, .redWbGain);

// *** cmt_gamma_model.sv ***
// partner model: external gamma stage with identity curve and fixed latency
`timescale 1ns/1ps
module cmt_gamma_model #(
  parameter int PW = 10,
  parameter int LAT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pixels from the native matrix
  input wire logic inValid,
  input wire logic inSof,
  input wire logic [PW-1:0] inR,
  input wire logic [PW-1:0] inG,
  input wire logic [PW-1:0] inB,
  // pixels back to the block
  output logic outValid,
  output logic outSof,
  output logic [PW-1:0] outR,
  output logic [PW-1:0] outG,
  output logic [PW-1:0] outB
);
  logic [3*PW+1:0] stage [LAT];
  logic [3*PW-1:0] last;
  // delay line; identity curve keeps matrix results checkable downstream
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < LAT; i++) stage[i] <= '0;
    end else begin
      stage[0] <= {inValid, inSof, inR, inG, inB};
      for (int i = 1; i < LAT; i++) stage[i] <= stage[i-1];
    end
  end
  // last valid data, so idle cycles never look like a held pixel
  always_ff @(posedge clk) begin
    if (reset) last <= '0;
    else if (outValid) last <= stage[LAT-1][3*PW-1:0];
  end
  assign outValid = stage[LAT-1][3*PW+1];
  assign outSof = stage[LAT-1][3*PW] & outValid;
  assign {outR, outG, outB} = outValid ? stage[LAT-1][3*PW-1:0] : ~last;
endmodule // cmt_gamma_model

// *** test_color_matrix_transform.sv ***
// self-checking bench for the colour matrix stage
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_color_matrix_transform;
  localparam int PW = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pixValid = 1'b0, pixSof = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, redWbGain, blueWbGain, monoRd;
  logic pready, pslverr, toGammaValid, toGammaSof, gamValid, gamSof, outValid, outSof;
  logic [PW-1:0] pixR = '0, pixG = '0, pixB = '0;
  logic [PW-1:0] toGammaR, toGammaG, toGammaB, gamR, gamG, gamB, out0, out1, out2;
  int err_count = 0, n_compared = 0;
  // device and the gamma stage it loops through
  cmt_color_matrix_transform #(.PW(PW)) i_dut (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pixValid, .pixSof, .pixR, .pixG,
    .pixB, .toGammaValid, .toGammaSof, .toGammaR, .toGammaG, .toGammaB, .gamValid,
    .gamSof, .gamR, .gamG, .gamB, .outValid, .outSof, .out0, .out1, .out2,
    .redWbGain, .blueWbGain);
  cmt_gamma_model #(.PW(PW), .LAT(2)) i_gam (.clk, .reset, .inValid(toGammaValid),
    .inSof(toGammaSof), .inR(toGammaR), .inG(toGammaG), .inB(toGammaB),
    .outValid(gamValid), .outSof(gamSof), .outR(gamR), .outG(gamG), .outB(gamB));
  // monochrome build on the same bus and pixels: its controls must stay hidden
  cmt_color_matrix_transform #(.PW(PW), .COLOR_VARIANT(1'b0)) i_mono (.clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata(monoRd), .pready(), .pslverr(), .pixValid,
    .pixSof, .pixR, .pixG, .pixB, .toGammaValid(), .toGammaSof(), .toGammaR(), .toGammaG(),
    .toGammaB(), .gamValid, .gamSof, .gamR, .gamG, .gamB, .outValid(), .outSof(), .out0(),
    .out1(), .out2(), .redWbGain(), .blueWbGain());
  always #5 clk = ~clk;
  // one apb transfer; reads compare data, every transfer compares the error
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic e, input string nm);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) `CHK(nm, d, prdata)
    `CHK(nm, e, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one pixel (r, 200, 300), final channels compared; idle lines show inverse
  task automatic px(input logic s, input logic [PW-1:0] r, e0, e1, e2, input string nm);
    int n;
    n = 0;
    @(posedge clk);
    pixValid <= 1'b1;
    pixSof <= s;
    pixR <= r;
    pixG <= 10'h0C8;
    pixB <= 10'h12C;
    @(posedge clk);
    pixValid <= 1'b0;
    pixSof <= 1'b0;
    pixR <= ~r;
    pixG <= 10'h337;
    pixB <= 10'h2D3;
    do begin @(posedge clk); #1; end while (outValid !== 1'b1 && ++n < 12);
    `CHK(nm, {1'b1, s}, {outValid, outSof})
    `CHK(nm, {e0, e1, e2}, {out0, out1, out2})
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("red gain", 32'h3F800000, redWbGain)
    acc(1'b0, cmt_pkg::OFF_UNIT_SEL, 32'h0, 1'b1, "gated read");
    acc(1'b1, cmt_pkg::OFF_RED_WB, 32'h40000000, 1'b1, "gated write");
    acc(1'b0, cmt_pkg::OFF_STATUS, 32'h0, 1'b0, "status off");
    px(1'b1, 10'h064, 10'h064, 10'h0C8, 10'h12C, "bypass");
    acc(1'b1, cmt_pkg::OFF_CTRL, 32'h1, 1'b0, "pipe on");
    acc(1'b0, 8'h40, 32'h0, 1'b1, "unmapped");
    acc(1'b1, cmt_pkg::OFF_ILLUMINANT, 32'h7, 1'b0, "custom");
    acc(1'b1, cmt_pkg::OFF_COEFF_VALUE, 32'h40000000, 1'b0, "gain write");
    acc(1'b1, cmt_pkg::OFF_COEFF_INDEX, 32'h9, 1'b0, "index");
    acc(1'b1, cmt_pkg::OFF_COEFF_VALUE, 32'h3E800000, 1'b0, "bias write");
    acc(1'b0, cmt_pkg::OFF_COEFF_VALUE, 32'h0, 1'b0, "bias before frame");
    px(1'b0, 10'h064, 10'h064, 10'h0C8, 10'h12C, "mid frame");
    px(1'b1, 10'h064, 10'h1C8, 10'h0C8, 10'h12C, "custom matrix");
    px(1'b1, 10'h258, 10'h3FF, 10'h0C8, 10'h12C, "clamp");
    acc(1'b0, cmt_pkg::OFF_COEFF_VALUE, 32'h3E800000, 1'b0, "bias in use");
    acc(1'b1, cmt_pkg::OFF_UNIT_ON, 32'h0, 1'b0, "matrix off");
    px(1'b0, 10'h064, 10'h1C8, 10'h0C8, 10'h12C, "off mid frame");
    px(1'b1, 10'h064, 10'h064, 10'h0C8, 10'h12C, "matrix bypass");
    acc(1'b1, cmt_pkg::OFF_UNIT_ON, 32'h1, 1'b0, "matrix on");
    $display("test matrix done");
    // every preset reloads the gains that software had overridden
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, cmt_pkg::OFF_RED_WB, 32'h40000000, 1'b0, "red write");
      acc(1'b1, cmt_pkg::OFF_BLUE_WB, 32'h40400000, 1'b0, "blue write");
      #1;
      `CHK("red override", 32'h40000000, redWbGain)
      acc(1'b1, cmt_pkg::OFF_ILLUMINANT, 32'(i), 1'b0, "preset");
      #1;
      `CHK("red preset", 32'h3F800000, redWbGain)
      `CHK("blue preset", 32'h3F800000, blueWbGain)
    end
    px(1'b1, 10'h064, 10'h064, 10'h0C8, 10'h12C, "preset ignores custom");
    $display("test presets done");
    acc(1'b1, cmt_pkg::OFF_UNIT_SEL, 32'h1, 1'b0, "luma select");
    acc(1'b1, cmt_pkg::OFF_UNIT_ON, 32'h1, 1'b0, "luma on write");
    acc(1'b0, cmt_pkg::OFF_UNIT_ON, 32'h0, 1'b0, "luma on kept");
    acc(1'b1, cmt_pkg::OFF_COEFF_INDEX, 32'h0, 1'b0, "index");
    acc(1'b1, cmt_pkg::OFF_COEFF_VALUE, 32'h40000000, 1'b0, "luma write");
    acc(1'b0, cmt_pkg::OFF_COEFF_VALUE, 32'h3E992000, 1'b0, "luma gain");
    acc(1'b1, cmt_pkg::OFF_COEFF_INDEX, 32'hA, 1'b0, "index");
    acc(1'b0, cmt_pkg::OFF_COEFF_VALUE, 32'h3F000000, 1'b0, "luma bias");
    acc(1'b1, cmt_pkg::OFF_COEFF_INDEX, 32'hC, 1'b0, "index");
    acc(1'b0, cmt_pkg::OFF_COEFF_VALUE, 32'h0, 1'b0, "index past end");
    acc(1'b1, cmt_pkg::OFF_CTRL, 32'h3, 1'b0, "yuv format");
    acc(1'b0, cmt_pkg::OFF_UNIT_ON, 32'h1, 1'b0, "luma follows format");
    px(1'b1, 10'h064, 10'h0B5, 10'h242, 10'h1C5, "yuv pixel");
    $display("test luma done");
    acc(1'b1, cmt_pkg::OFF_CTRL, 32'h1, 1'b0, "rgb format");
    acc(1'b1, cmt_pkg::OFF_SATURATION, 32'h0, 1'b0, "saturation zero");
    px(1'b1, 10'h064, 10'h064, 10'h0C8, 10'h12C, "saturation off");
    acc(1'b1, cmt_pkg::OFF_CTRL, 32'h5, 1'b0, "saturation on");
    px(1'b1, 10'h064, 10'h0C8, 10'h0C8, 10'h0C8, "saturation on");
    acc(1'b0, cmt_pkg::OFF_STATUS, 32'hB, 1'b0, "status live");
    `CHK("mono status", 32'h0, monoRd)
    $display("test saturation done");
    stop_test();
  end
endmodule // test_color_matrix_transform
